// ---- core/ppl_defs.svh ----
`ifndef PPL_DEFS_SVH
`define PPL_DEFS_SVH

// ----------------------------------------------------------------------------
// parameter numbers of the two lock parameters
// ----------------------------------------------------------------------------
`define PPL_NUM_LOCK_LEVEL 10'h128
`define PPL_NUM_PASSWORD 10'h129

// ----------------------------------------------------------------------------
// values and reset values
// ----------------------------------------------------------------------------
`define PPL_VAL_NONE 16'h270F
`define PPL_VAL_ZERO 16'h0000
`define PPL_LOCK_LEVEL_RST 16'h270F
`define PPL_PASSWORD_RST 16'h270F
`define PPL_PW_MIN 16'h03E8
`define PPL_PW_MAX 16'h270E
`define PPL_LVL_LO_MAX 16'h0006
`define PPL_LVL_GROUP 16'h0063
`define PPL_LVL_HI_BASE 16'h0064
`define PPL_LVL_HI_MAX 16'h006A
`define PPL_LVL_HI_GROUP 16'h00C7
`define PPL_UGR_ALL 16'h0000
`define PPL_UGR_GROUP 16'h0001
`define PPL_UGR_SIMPLE 16'h270F
`define PPL_WS_STOP_ONLY 16'h0000
`define PPL_WS_NEVER 16'h0001
`define PPL_SRC_SEL_OPTION 16'h0000
`define PPL_SRC_SEL_RS485 16'h0001
`define PPL_SRC_SEL_AUTO 16'h270F
`define PPL_ERR_LIMIT 3'h5
`define PPL_ERR_RST 3'h0

// ----------------------------------------------------------------------------
// clear data codes
// ----------------------------------------------------------------------------
`define PPL_CODE_ALL_A 16'h9966
`define PPL_CODE_ALL_B 16'h55AA
`define PPL_CODE_PAR_A 16'h9696
`define PPL_CODE_PAR_B 16'h5A5A

// ----------------------------------------------------------------------------
// access masks per level, bits {pu_rd, pu_wr, net_rd, net_wr}
// ----------------------------------------------------------------------------
`define PPL_MASK_L0 4'h0
`define PPL_MASK_L1 4'hA
`define PPL_MASK_L2 4'hB
`define PPL_MASK_L3 4'hE
`define PPL_MASK_L4 4'h2
`define PPL_MASK_L5 4'h3
`define PPL_MASK_L6 4'hC
`define PPL_MASK_ALL 4'hF

`endif

// ---- core/ppl_pkg.sv ----
package ppl_pkg;

    // ------------------------------------------------------------------------
    // requesting party
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PPL_SRC_PANEL = 2'h0,
        PPL_SRC_RS485 = 2'h1,
        PPL_SRC_OPTION = 2'h2
    } ppl_src_t;

    // answer codes
    typedef enum logic [2:0] {
        PPL_ST_OK = 3'h0,
        PPL_ST_LOCK_IND = 3'h1,
        PPL_ST_DENIED = 3'h2,
        PPL_ST_PW_ERR = 3'h3,
        PPL_ST_RANGE = 3'h4
    } ppl_status_t;

    // lock state, one-hot
    typedef enum logic [1:0] {
        PPL_OPEN = 2'b01,
        PPL_LOCKED = 2'b10
    } ppl_state_t;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        ppl_src_t src;
        logic is_write;
        logic [9:0] param_num;
        logic [15:0] wdata;
        logic is_simple;
        logic in_user_group;
    } ppl_req_t;

    typedef struct packed {
        ppl_status_t status;
        logic [15:0] rdata;
    } ppl_resp_t;

    typedef struct packed {
        logic [15:0] user_group_read_select;
        logic [15:0] write_select_param;
        logic [15:0] net_command_source_select;
        logic [15:0] panel_command_source_select;
    } ppl_cfg_t;

endpackage : ppl_pkg

// ---- core/ppl_lock_gate.sv ----
`timescale 1ns/10ps
`include "ppl_defs.svh"

module ppl_lock_gate (
    // level and request
    input wire logic [15:0] level,
    input wire logic is_write,
    input wire logic pu_path,
    input wire logic in_user_group,
    // verdict
    output logic allow
);
    import ppl_pkg::*;

    logic [3:0] mask;
    logic [1:0] pair;
    wire logic hi_level = (level >= `PPL_LVL_HI_BASE);
    wire logic [15:0] base = hi_level ? (level - `PPL_LVL_HI_BASE) : level;

    // ------------------------------------------------------------------------
    // level to mask; group levels fall back to level four outside the group
    // ------------------------------------------------------------------------
    always_comb begin
        case (base)
            16'h0000: mask = `PPL_MASK_L0;
            16'h0001: mask = `PPL_MASK_L1;
            16'h0002: mask = `PPL_MASK_L2;
            16'h0003: mask = `PPL_MASK_L3;
            16'h0004: mask = `PPL_MASK_L4;
            16'h0005: mask = `PPL_MASK_L5;
            16'h0006: mask = `PPL_MASK_L6;
            default: mask = in_user_group ? `PPL_MASK_ALL : `PPL_MASK_L4;
        endcase
    end

    // pick the source half, then read or write
    assign pair = pu_path ? mask[3:2] : mask[1:0];
    assign allow = is_write ? pair[0] : pair[1];

endmodule : ppl_lock_gate

// ---- core/ppl_password_lock.sv ----
`timescale 1ns/10ps
`include "ppl_defs.svh"

// ----------------------------------------------------------------------------
// Overview of operation
// - levels 0-6, 99, 100-106, 199 restrict; 9999 means no lock, reset value.
// - password 1000-9998 written registers it unless level is 9999; level then applies until unlocked.
// - level 9999: password writable only at group select 0; locked: always.
// - password reads error count for levels 100+, else 0, once registered.
// - levels 100+ refuse unlock after five failed attempts.
// - matching password unlocks; mismatch errors, counts a failure, stays locked.
// - all clear unlocks whenever the drive is stopped and resets all other settings.
// - all clear refused while the drive runs.
// - password writes of 0 or 9999 accepted with no effect.
// - restriction chosen per read/write and per panel or network source.
// - group levels allow group members; others treated as level four.
// - lock level and password parameters readable while locked; password writable then, lock level not.
// - allowed accesses still refused by group read or write selection.
// - password blocked access answered with a lock indication.
// - internal updates overwrite parameters even while locked.
// - all clear codes unlock from panel, RS-485 or option.
// - plain clear codes unlock only from the option.
// - lock parameters changeable while running regardless of write selection.
// - level 0 or 100 while locked with option fitted raises option fault trip.
// - lock level accepts new setting only at group read select 0.
// ----------------------------------------------------------------------------

module ppl_password_lock (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // parameter access request
    input wire logic req_valid,
    input wire ppl_pkg::ppl_req_t req,
    // parameter access answer
    output logic resp_valid,
    output ppl_pkg::ppl_resp_t resp,
    output logic access_grant,
    // clear request
    input wire logic clr_valid,
    input wire ppl_pkg::ppl_src_t clr_src,
    input wire logic [15:0] clr_code,
    // clear answer and actions towards the store
    output logic clr_resp_valid,
    output ppl_pkg::ppl_status_t clr_status,
    output logic all_clear_pulse,
    output logic param_clear_pulse,
    // internal update path
    input wire logic int_wr_req,
    output logic int_wr_grant,
    // drive settings and state
    input wire ppl_pkg::ppl_cfg_t cfg,
    input wire logic drive_running,
    input wire logic option_installed,
    // lock state outputs
    output logic lock_active,
    output logic option_fault_trip,
    output logic [15:0] lock_level,
    output logic [2:0] unlock_err_count
);
    import ppl_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    ppl_state_t state_q, state_d;
    logic [15:0] level_q, level_d;
    logic [15:0] pw_q, pw_d;
    logic [2:0] err_q, err_d;
    logic fault_q, fault_d;
    logic resp_valid_q;
    ppl_resp_t resp_q, resp_d;
    logic grant_q, grant_d;
    logic clr_resp_valid_q;
    ppl_status_t clr_status_q, clr_status_d;
    logic all_clr_q, par_clr_q;

    // actions decided by the request and clear decoders
    logic lvl_wr_en;
    logic pw_reg_en;
    logic pw_unlock;
    logic err_inc;
    logic do_all_clr;
    logic do_par_clr;
    logic clr_unlock;

    // ------------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------------
    wire logic locked = (state_q == PPL_LOCKED);
    wire logic is_level_param = (req.param_num == `PPL_NUM_LOCK_LEVEL);
    wire logic is_pw_param = (req.param_num == `PPL_NUM_PASSWORD);
    wire logic is_lock_param = is_level_param | is_pw_param;
    wire logic level_none = (level_q == `PPL_VAL_NONE);
    wire logic hi_level = (level_q >= `PPL_LVL_HI_BASE) & ~level_none;
    wire logic ugr_zero = (cfg.user_group_read_select == `PPL_UGR_ALL);

    // which column of the table the caller falls in
    wire logic pu_is_rs485 = (cfg.panel_command_source_select == `PPL_SRC_SEL_RS485);
    wire logic pu_path = ((req.src == PPL_SRC_PANEL) & ~pu_is_rs485) |
                         ((req.src == PPL_SRC_RS485) & pu_is_rs485);

    // group read selection only binds some callers; the option always reads all
    wire logic net_sel_rs485 = (cfg.net_command_source_select == `PPL_SRC_SEL_RS485);
    wire logic net_sel_auto = (cfg.net_command_source_select == `PPL_SRC_SEL_AUTO);
    wire logic rs485_ugr_on = pu_is_rs485 | ~(net_sel_rs485 | (net_sel_auto & ~option_installed));
    wire logic ugr_applies = (req.src == PPL_SRC_PANEL) |
                             ((req.src == PPL_SRC_RS485) & rs485_ugr_on);
    wire logic ugr_hides = ((cfg.user_group_read_select == `PPL_UGR_SIMPLE) & ~req.is_simple) |
                           ((cfg.user_group_read_select == `PPL_UGR_GROUP) & ~req.in_user_group);
    wire logic ugr_block_rd = ugr_applies & ugr_hides;

    // write selection: 1 blocks all ordinary writes, 0 blocks them while running
    wire logic ws_block_wr = (cfg.write_select_param == `PPL_WS_NEVER) |
                             ((cfg.write_select_param == `PPL_WS_STOP_ONLY) & drive_running);

    // value checks on the write data
    wire logic [15:0] wv = req.wdata;
    wire logic wv_level_ok = (wv <= `PPL_LVL_LO_MAX) | (wv == `PPL_LVL_GROUP) |
                             ((wv >= `PPL_LVL_HI_BASE) & (wv <= `PPL_LVL_HI_MAX)) |
                             (wv == `PPL_LVL_HI_GROUP) | (wv == `PPL_VAL_NONE);
    wire logic wv_pw_ok = (wv >= `PPL_PW_MIN) & (wv <= `PPL_PW_MAX);
    wire logic wv_pw_noop = (wv == `PPL_VAL_ZERO) | (wv == `PPL_VAL_NONE);
    wire logic pw_match = (wv == pw_q);
    wire logic err_at_limit = hi_level & (err_q == `PPL_ERR_LIMIT);

    // lock table verdict for ordinary parameters
    logic lock_allow;

    ppl_lock_gate u_gate (
        .level(level_q),
        .is_write(req.is_write),
        .pu_path(pu_path),
        .in_user_group(req.in_user_group),
        .allow(lock_allow)
    );

    wire logic lock_block = locked & ~is_lock_param & ~lock_allow;

    // password read value depends on the lock state
    wire logic [15:0] pw_read = ~locked ? `PPL_VAL_NONE :
                                hi_level ? {13'h0000, err_q} : `PPL_VAL_ZERO;

    // ------------------------------------------------------------------------
    // request handling: answer and effects, one request per cycle
    // ------------------------------------------------------------------------
    always_comb begin
        resp_d = '{status: PPL_ST_OK, rdata: 16'h0000};
        grant_d = 1'b0;
        lvl_wr_en = 1'b0;
        pw_reg_en = 1'b0;
        pw_unlock = 1'b0;
        err_inc = 1'b0;
        if (req_valid) begin
            if (lock_block) begin
                resp_d.status = PPL_ST_LOCK_IND;
            end else if (!req.is_write) begin
                // lock parameters stay readable once a lock exists
                if (ugr_block_rd & ~(is_lock_param & locked)) begin
                    resp_d.status = PPL_ST_DENIED;
                end else if (is_level_param) begin
                    resp_d.rdata = level_q;
                end else if (is_pw_param) begin
                    resp_d.rdata = pw_read;
                end else begin
                    grant_d = 1'b1;
                end
            end else if (is_level_param) begin
                // write selection and running state never matter here
                if (locked) begin
                    resp_d.status = PPL_ST_LOCK_IND;
                end else if (!ugr_zero) begin
                    resp_d.status = PPL_ST_DENIED;
                end else if (!wv_level_ok) begin
                    resp_d.status = PPL_ST_RANGE;
                end else begin
                    lvl_wr_en = 1'b1;
                end
            end else if (is_pw_param) begin
                if (wv_pw_noop) begin
                    resp_d.status = PPL_ST_OK;
                end else if (!wv_pw_ok) begin
                    resp_d.status = PPL_ST_RANGE;
                end else if (locked) begin
                    // compare against the stored password
                    if (pw_match & ~err_at_limit) begin
                        pw_unlock = 1'b1;
                    end else begin
                        resp_d.status = PPL_ST_PW_ERR;
                        err_inc = 1'b1;
                    end
                end else if (level_none & ~ugr_zero) begin
                    resp_d.status = PPL_ST_DENIED;
                end else begin
                    pw_reg_en = ~level_none;
                end
            end else if (ws_block_wr) begin
                resp_d.status = PPL_ST_DENIED;
            end else begin
                grant_d = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // clear handling
    // ------------------------------------------------------------------------
    wire logic code_all = (clr_code == `PPL_CODE_ALL_A) | (clr_code == `PPL_CODE_ALL_B);
    wire logic code_par = (clr_code == `PPL_CODE_PAR_A) | (clr_code == `PPL_CODE_PAR_B);
    wire logic clr_from_opt = (clr_src == PPL_SRC_OPTION);

    always_comb begin
        clr_status_d = PPL_ST_OK;
        do_all_clr = 1'b0;
        do_par_clr = 1'b0;
        clr_unlock = 1'b0;
        if (clr_valid) begin
            if (!(code_all | code_par)) begin
                clr_status_d = PPL_ST_RANGE;
            end else if (drive_running) begin
                clr_status_d = PPL_ST_DENIED;
            end else if (code_all) begin
                do_all_clr = 1'b1;
            end else if (locked & ~clr_from_opt) begin
                clr_status_d = PPL_ST_LOCK_IND;
            end else begin
                do_par_clr = 1'b1;
                clr_unlock = locked;
            end
        end
    end

    // ------------------------------------------------------------------------
    // next values; a clear takes precedence over a request in the same cycle
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        level_d = level_q;
        pw_d = pw_q;
        err_d = err_q;
        if (do_all_clr) begin
            state_d = PPL_OPEN;
            level_d = `PPL_LOCK_LEVEL_RST;
            pw_d = `PPL_PASSWORD_RST;
            err_d = `PPL_ERR_RST;
        end else if (clr_unlock | pw_unlock) begin
            state_d = PPL_OPEN;
            pw_d = `PPL_PASSWORD_RST;
            err_d = `PPL_ERR_RST;
        end else if (pw_reg_en) begin
            state_d = PPL_LOCKED;
            pw_d = wv;
            err_d = `PPL_ERR_RST;
        end else begin
            if (lvl_wr_en) begin
                level_d = wv;
            end
            // saturate so the count never shows above the limit
            if (err_inc & (err_q != `PPL_ERR_LIMIT)) begin
                err_d = err_q + 3'h1;
            end
        end
    end

    // option fault: set wins over the clear done by an all clear
    wire logic level_blocks_all = (level_q == 16'h0000) | (level_q == `PPL_LVL_HI_BASE);
    wire logic fault_set = locked & level_blocks_all & option_installed;
    assign fault_d = fault_set | (fault_q & ~do_all_clr);

    // ------------------------------------------------------------------------
    // lock registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= PPL_OPEN;
            level_q <= `PPL_LOCK_LEVEL_RST;
            pw_q <= `PPL_PASSWORD_RST;
            err_q <= `PPL_ERR_RST;
        end else begin
            state_q <= state_d;
            level_q <= level_d;
            pw_q <= pw_d;
            err_q <= err_d;
        end
    end

    // fault register kept apart so the trip holds until an all clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
        end
    end

    // ------------------------------------------------------------------------
    // answer registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resp_valid_q <= 1'b0;
            resp_q <= '{status: PPL_ST_OK, rdata: 16'h0000};
            grant_q <= 1'b0;
        end else begin
            resp_valid_q <= req_valid;
            resp_q <= resp_d;
            grant_q <= grant_d;
        end
    end

    // clear answer and store actions
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clr_resp_valid_q <= 1'b0;
            clr_status_q <= PPL_ST_OK;
            all_clr_q <= 1'b0;
            par_clr_q <= 1'b0;
        end else begin
            clr_resp_valid_q <= clr_valid;
            clr_status_q <= clr_status_d;
            all_clr_q <= do_all_clr;
            par_clr_q <= do_par_clr;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign resp_valid = resp_valid_q;
    assign resp = resp_q;
    assign access_grant = grant_q;
    assign clr_resp_valid = clr_resp_valid_q;
    assign clr_status = clr_status_q;
    assign all_clear_pulse = all_clr_q;
    assign param_clear_pulse = par_clr_q;
    // internal updates bypass the lock entirely, no wait state
    assign int_wr_grant = int_wr_req;
    assign lock_active = locked;
    assign option_fault_trip = fault_q;
    assign lock_level = level_q;
    assign unlock_err_count = err_q;

endmodule : ppl_password_lock

// ---- test/ppl_lock_asserts.sv ----
`timescale 1ns/10ps
// --------
// lock checker
// --------
module ppl_lock_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // requests and settings
    input wire logic req_valid,
    input wire ppl_pkg::ppl_req_t req,
    input wire logic clr_valid,
    input wire logic [15:0] clr_code,
    input wire logic int_wr_req,
    input wire ppl_pkg::ppl_cfg_t cfg,
    input wire logic drive_running,
    input wire logic option_installed,
    // answers and state
    input wire logic resp_valid,
    input wire ppl_pkg::ppl_resp_t resp,
    input wire ppl_pkg::ppl_status_t clr_status,
    input wire logic all_clear_pulse,
    input wire logic int_wr_grant,
    input wire logic lock_active,
    input wire logic option_fault_trip,
    input wire logic [15:0] lock_level,
    input wire logic [2:0] unlock_err_count
);
    import ppl_pkg::*;
    // password writes not raced by a clear
    wire pw_wr = req_valid && req.is_write && req.param_num == 10'h129 && !clr_valid;
    wire hi_lvl = lock_level >= 16'h0064 && lock_level != 16'h270F;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_resp_follows:
        assert property (req_valid |=> resp_valid) else $error("no answer");
    a_run_blocks_clear:
        assert property (clr_valid && drive_running && (clr_code == 16'h9966
            || clr_code == 16'h55AA) |=> clr_status == PPL_ST_DENIED && !all_clear_pulse)
            else $error("clear while running");
    a_clear_unlocks:
        assert property (all_clear_pulse |-> !lock_active && unlock_err_count == 3'h0
            && lock_level == 16'h270F) else $error("lock left by clear");
    a_count_cap:
        assert property (unlock_err_count <= 3'h5) else $error("count over five");
    a_limit_holds:
        assert property (lock_active && hi_lvl && unlock_err_count == 3'h5 && pw_wr
            |=> lock_active) else $error("unlocked past limit");
    a_dummy_write:
        assert property (pw_wr && (req.wdata == 16'h0000 || req.wdata == 16'h270F)
            |=> $stable(lock_active) && resp.status == PPL_ST_OK) else $error("dummy write acted");
    a_int_passes:
        assert property (int_wr_req |-> int_wr_grant) else $error("update blocked");
    a_opt_trip:
        assert property (lock_active && option_installed && (lock_level == 16'h0000
            || lock_level == 16'h0064) |-> ##[0:2] option_fault_trip) else $error("no trip");
    a_err_keeps_lock:
        assert property (pw_wr ##1 resp.status == PPL_ST_PW_ERR |-> lock_active)
        else $error("unlocked on error");
    a_open_pw_denied:
        assert property (!lock_active && lock_level == 16'h270F && pw_wr
            && cfg.user_group_read_select != 16'h0000 && req.wdata >= 16'h03E8
            && req.wdata <= 16'h270E |=> resp.status == PPL_ST_DENIED) else $error("pw taken");
    c_all_clear: cover property (all_clear_pulse);
    c_locked: cover property ($rose(lock_active));
    c_trip: cover property (option_fault_trip);
endmodule : ppl_lock_asserts

bind ppl_password_lock ppl_lock_asserts chk_i (.*);

// ---- test/ppl_host_model.sv ----
`timescale 1ns/10ps
// --------
// panel, RS-485 or option host
// --------
module ppl_host_model (
    // clock
    input wire logic sys_clk,
    // access request and answer
    output logic req_valid,
    output ppl_pkg::ppl_req_t req,
    input wire logic resp_valid,
    input wire ppl_pkg::ppl_resp_t resp,
    // clear request and answer
    output logic clr_valid,
    output ppl_pkg::ppl_src_t clr_src,
    output logic [15:0] clr_code,
    input wire logic clr_resp_valid,
    input wire ppl_pkg::ppl_status_t clr_status
);
    import ppl_pkg::*;
    ppl_resp_t got;
    ppl_status_t got_clr;
    // idle lines at time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
        clr_valid = 1'b0;
        clr_src = PPL_SRC_PANEL;
        clr_code = 16'h0000;
    end
    // stale data inverted on release
    task automatic acc(input ppl_src_t s, input logic w, input logic [9:0] n,
        input logic [15:0] d);
        @(negedge sys_clk);
        req_valid <= 1'b1;
        req <= '{s, w, n, d, 1'b0, 1'b0};
        @(negedge sys_clk);
        got = resp;
        req_valid <= 1'b0;
        req <= ~req;
    endtask : acc
    // clear request, answer taken one cycle on
    task automatic clr(input ppl_src_t s, input logic [15:0] c);
        @(negedge sys_clk);
        clr_valid <= 1'b1;
        clr_src <= s;
        clr_code <= c;
        @(negedge sys_clk);
        got_clr = clr_status;
        clr_valid <= 1'b0;
        clr_code <= ~clr_code;
    endtask : clr
endmodule : ppl_host_model

// ---- test/tb.sv ----
`timescale 1ns/10ps
`include "ppl_defs.svh"
// --------
// password lock bench
// --------
module tb;
    import ppl_pkg::*;
    localparam logic [9:0] lv = `PPL_NUM_LOCK_LEVEL;
    localparam logic [9:0] pw = `PPL_NUM_PASSWORD;
    logic sys_clk, rst, int_wr_req, drive_running, option_installed;
    logic req_valid, resp_valid, access_grant, clr_valid, clr_resp_valid, all_clear_pulse;
    logic param_clear_pulse, int_wr_grant, lock_active, option_fault_trip;
    logic [15:0] clr_code, lock_level;
    logic [2:0] unlock_err_count;
    ppl_req_t req;
    ppl_resp_t resp;
    ppl_src_t clr_src;
    ppl_status_t clr_status;
    ppl_cfg_t cfg;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    ppl_password_lock dut (.*);
    ppl_host_model h (.*);
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic flg(input string nm, input logic e, input logic g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask : flg
    task automatic st(input ppl_status_t e, input ppl_status_t g);
        chk("status", {13'h0000, e}, {13'h0000, g});
    endtask : st
    task automatic wr(input logic [9:0] n, input logic [15:0] d,
        input ppl_src_t s = PPL_SRC_PANEL);
        h.acc(s, 1'b1, n, d);
    endtask : wr
    task automatic rd(input logic [9:0] n);
        h.acc(PPL_SRC_PANEL, 1'b0, n, 16'h0000);
    endtask : rd
    // clock, 4 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard, run needs about 90 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            end_sim;
        end
    end
    initial begin
        rst = 1'b1;
        int_wr_req = 1'b0;
        drive_running = 1'b0;
        option_installed = 1'b0;
        cfg = '{16'h0001, 16'h0000, 16'h270F, 16'h270F};
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        chk("level", 16'h270F, lock_level);
        wr(pw, 16'd1234);
        st(PPL_ST_DENIED, h.got.status);
        wr(lv, 16'd103);
        st(PPL_ST_DENIED, h.got.status);
        cfg.user_group_read_select = 16'h0000;
        wr(pw, 16'd1234);
        flg("lock", 1'b0, lock_active);
        wr(lv, 16'd103);
        chk("level", 16'd103, lock_level);
        drive_running = 1'b1;
        cfg.write_select_param = 16'h0001;
        wr(pw, 16'd1234);
        flg("lock", 1'b1, lock_active);
        rd(pw);
        chk("count", 16'h0000, h.got.rdata);
        rd(lv);
        chk("level", 16'd103, h.got.rdata);
        wr(10'd7, 16'h0005);
        st(PPL_ST_DENIED, h.got.status);
        drive_running = 1'b0;
        cfg.write_select_param = 16'h0000;
        wr(10'd7, 16'h0005, PPL_SRC_OPTION);
        st(PPL_ST_LOCK_IND, h.got.status);
        wr(10'd7, 16'h0005);
        flg("grant", 1'b1, access_grant);
        int_wr_req = 1'b1;
        #1 flg("int", 1'b1, int_wr_grant);
        int_wr_req = 1'b0;
        wr(pw, 16'd1111);
        st(PPL_ST_PW_ERR, h.got.status);
        wr(pw, 16'h0000);
        st(PPL_ST_OK, h.got.status);
        wr(pw, 16'h270F);
        rd(pw);
        chk("count", 16'h0001, h.got.rdata);
        repeat (4) wr(pw, 16'd1111, PPL_SRC_RS485);
        wr(pw, 16'd1234);
        st(PPL_ST_PW_ERR, h.got.status);
        chk("count", 16'h0005, {13'h0000, unlock_err_count});
        drive_running = 1'b1;
        h.clr(PPL_SRC_PANEL, 16'h9966);
        st(PPL_ST_DENIED, h.got_clr);
        flg("cvalid", 1'b1, clr_resp_valid);
        drive_running = 1'b0;
        h.clr(PPL_SRC_PANEL, 16'h9966);
        flg("all", 1'b1, all_clear_pulse);
        flg("lock", 1'b0, lock_active);
        chk("count", 16'h0000, {13'h0000, unlock_err_count});
        chk("level", 16'h270F, lock_level);
        // every source with plain then all clear codes
        for (int i = 0; i < 3; i++) begin
            wr(lv, 16'd3);
            wr(pw, 16'd2000);
            h.clr(ppl_src_t'(i), i[0] ? 16'h5A5A : 16'h9696);
            flg("plain", i != 2, lock_active);
            flg("pclr", i == 2, param_clear_pulse);
            h.clr(ppl_src_t'(i), i[0] ? 16'h55AA : 16'h9966);
            flg("all", 1'b0, lock_active);
        end
        wr(lv, 16'd0);
        option_installed = 1'b1;
        wr(pw, 16'd2000);
        repeat (2) @(negedge sys_clk);
        flg("trip", 1'b1, option_fault_trip);
        wr(pw, 16'd2000);
        flg("lock", 1'b0, lock_active);
        wr(lv, 16'd199);
        wr(pw, 16'd2000);
        rd(10'd7);
        st(PPL_ST_LOCK_IND, h.got.status);
        end_sim;
    end
endmodule : tb
